// File: design/iwc_pkg.sv
// Package for the interrupt, wake and context unit.
// Assumes a single 25 MHz clock and an 8-bit register port.
package iwc_pkg;

    // Register map, word offsets on the plain register port
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_ENABLE0   = 8'h01;
    localparam logic [7:0] ADDR_FLAG0     = 8'h02;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h03;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h04;
    localparam logic [7:0] ADDR_SHADOW_LO = 8'h10;
    localparam logic [7:0] ADDR_SHADOW_HI = 8'h17;
    localparam logic [7:0] SHADOW_BANK    = 8'h1F;

    // Control register fields
    localparam int CTRL_GIE_BIT  = 7;
    localparam int CTRL_PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int CTRL_EDGE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h01;

    // Enable register zero fields
    localparam int EN_TMR0_BIT = 5;
    localparam int EN_IOC_BIT  = 4;
    localparam int EN_EXT_BIT  = 0;
    localparam logic [7:0] EN0_WMASK = 8'h31;

    // Event status bits
    localparam int EV_EXT   = 0;
    localparam int EV_WAKE  = 1;
    localparam int EV_ENTRY = 2;
    localparam int EV_RET   = 3;
    localparam logic [7:0] EV_WMASK = 8'h0F;

    localparam logic [14:0] IRQ_VECTOR = 15'h0004;
    localparam logic [7:0]  STATUS_KEEP = 8'hE7;
    localparam int SHADOW_WORDS = 8;
    localparam int NUM_PERIPH   = 4;

    // Q-phase sequencing
    typedef enum logic [1:0] {
        IWC_Q1 = 2'b00,
        IWC_Q2 = 2'b01,
        IWC_Q3 = 2'b10,
        IWC_Q4 = 2'b11
    } iwc_q_t;

    // Core context carried to and from the shadow copies
    typedef struct packed {
        logic [7:0] w;
        logic [7:0] status;
        logic [7:0] bank_select_reg;
        logic [7:0] fsr0l;
        logic [7:0] fsr0h;
        logic [7:0] fsr1l;
        logic [7:0] fsr1h;
        logic [7:0] pc_high_latch;
    } iwc_ctx_t;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iwc_bus_t;

endpackage : iwc_pkg

// File: design/iwc_shadow_mem.sv
// Shadow context memory: eight bytes, registered read.
// Assumes one writer per cycle; entry snapshot wins over software.
`timescale 1ns/10ps
module iwc_shadow_mem (
    input  wire logic           mclk_i,
    input  wire logic           rst_b_i,
    input  wire logic           snap_i,
    input  wire iwc_pkg::iwc_ctx_t ctx_i,
    input  wire logic           wr_i,
    input  wire logic [2:0]     waddr_i,
    input  wire logic [7:0]     wdata_i,
    input  wire logic [2:0]     raddr_i,
    output logic [7:0]          rdata_o,
    output iwc_pkg::iwc_ctx_t   ctx_o
);
    typedef struct packed {
        logic [iwc_pkg::SHADOW_WORDS-1:0][7:0] mem;
        logic [7:0]                            rdata;
    } iwc_shm_t;

    iwc_shm_t st;
    iwc_shm_t next_st;

    // Snapshot or byte write, then registered read
    always_comb begin
        next_st = st;
        if (snap_i) begin
            next_st.mem = ctx_i;
        end else if (wr_i) begin
            next_st.mem[waddr_i] = wdata_i;
        end
        next_st.rdata = st.mem[raddr_i];
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign ctx_o   = st.mem;
endmodule : iwc_shadow_mem

// File: design/iwc_edge_det.sv
// External pin edge detector with selectable polarity.
// Assumes the pin is synchronous to the clock per integration.
`timescale 1ns/10ps
module iwc_edge_det (
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic pin_i,
    input  wire logic rising_i,
    output logic      edge_o
);
    typedef struct packed {
        logic prev;
        logic armed;
    } iwc_edge_t;

    iwc_edge_t st;
    iwc_edge_t next_st;

    // Remember last pin level; first cycle after reset only learns it
    always_comb begin
        next_st.prev  = pin_i;
        next_st.armed = 1'b1;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Valid edge per chosen polarity, no false edge out of reset
    assign edge_o = st.armed &
        (rising_i ? (pin_i & ~st.prev) : (~pin_i & st.prev));
endmodule : iwc_edge_det

// File: design/iwc_ctrl.sv
// Interrupt control, wake from sleep and context save/restore.
// Assumes the core sequencer drives sleep, instruction-done and return
// strobes and honours the entry, vector and restore outputs.
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
module iwc_ctrl (
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire iwc_pkg::iwc_bus_t bus_i,
    input  wire logic [7:0]        bank_i,
    output logic [7:0]             rdata_o,
    input  wire logic              ext_pin_i,
    input  wire logic              tmr0_evt_i,
    input  wire logic              ioc_evt_i,
    input  wire logic [3:0]        periph_flag_i,
    input  wire logic [3:0]        periph_en_i,
    input  wire logic              sleep_i,
    input  wire logic              instr_done_i,
    input  wire logic              return_from_irq_i,
    input  wire logic [14:0]       pc_i,
    input  wire iwc_pkg::iwc_ctx_t ctx_i,
    output logic                   wake_o,
    output logic                   flush_o,
    output logic                   push_o,
    output logic [14:0]            push_pc_o,
    output logic                   vector_o,
    output logic [14:0]            vector_pc_o,
    output logic                   pop_o,
    output logic                   restore_o,
    output iwc_pkg::iwc_ctx_t      restore_ctx_o,
    output logic [1:0]             qphase_o,
    output logic                   irq_o
);
    typedef struct packed {
        logic              global_irq_enable;
        logic              peripheral_irq_enable;
        logic              edge_rise;
        logic              en_tmr0;
        logic              en_ioc;
        logic              en_ext;
        logic              flg_tmr0;
        logic              flg_ioc;
        logic              flg_ext;
        logic              sleeping;
        logic              post_wake;
        logic              flush;
        logic              push;
        logic              vector;
        logic              pop;
        logic              restore;
        logic [14:0]       push_pc;
        logic [7:0]        rdata;
        logic              rd_shadow;
        logic [3:0]        ev_stat;
        logic [3:0]        ev_mask;
        iwc_pkg::iwc_q_t   q;
    } iwc_st_t;

    iwc_st_t st;
    iwc_st_t next_st;

    logic       ext_edge;
    logic [7:0] shadow_rdata;
    logic       shadow_wr;
    logic       any_pend;
    logic       entry;
    logic       is_shadow;
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    iwc_pkg::iwc_ctx_t save_ctx;

    // Bit-clear-by-one helper for sticky flags
    function automatic logic w1c(input logic cur, input logic set,
                                 input logic clr);
        w1c = set | (cur & ~clr);
    endfunction : w1c

    //////////////////////////////////////////////////////////////////////////
    // Pin edge detector and shadow memory
    iwc_edge_det u_edge (
        .mclk_i   (mclk_i),
        .rst_b_i  (rst_b_i),
        .pin_i    (ext_pin_i),
        .rising_i (st.edge_rise),
        .edge_o   (ext_edge)
    );

    // Status keeps live timeout and powerdown out of the copy
    always_comb begin
        save_ctx = ctx_i;
        save_ctx.status = ctx_i.status & iwc_pkg::STATUS_KEEP;
    end

    // Shadow window sits in bank 31
    assign is_shadow = (bank_i == iwc_pkg::SHADOW_BANK) &&
                       (bus_i.addr >= iwc_pkg::ADDR_SHADOW_LO) &&
                       (bus_i.addr <= iwc_pkg::ADDR_SHADOW_HI);
    assign shadow_wr = bus_i.wr & is_shadow;

    iwc_shadow_mem u_shadow (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .snap_i  (entry),
        .ctx_i   (save_ctx),
        .wr_i    (shadow_wr),
        .waddr_i (bus_i.addr[2:0]),
        .wdata_i (bus_i.wdata),
        .raddr_i (bus_i.addr[2:0]),
        .rdata_o (shadow_rdata),
        .ctx_o   (restore_ctx_o)
    );

    //////////////////////////////////////////////////////////////////////////
    // Pending source: enabled flag, peripherals behind peripheral enable
    always_comb begin
        any_pend = (st.flg_ext & st.en_ext)
                 | (st.flg_tmr0 & st.en_tmr0)
                 | (st.flg_ioc & st.en_ioc)
                 | (st.peripheral_irq_enable & |(periph_flag_i & periph_en_i));
    end

    // Take only when enabled globally, awake, and past the post-wake slot
    assign entry = any_pend & st.global_irq_enable & ~st.sleeping & ~st.post_wake
                 & ~st.flush & ~st.vector & ~return_from_irq_i;

    //////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        next_st.flush   = 1'b0;
        next_st.push    = 1'b0;
        next_st.vector  = 1'b0;
        next_st.pop     = 1'b0;
        next_st.restore = 1'b0;
        next_st.q       = iwc_pkg::iwc_q_t'(st.q + 2'b01);

        // External flag may land only in Q4 or Q1
        if (ext_edge && (st.q == iwc_pkg::IWC_Q4 ||
                         st.q == iwc_pkg::IWC_Q1)) begin
            next_st.flg_ext = 1'b1;
        end
        if (tmr0_evt_i) begin
            next_st.flg_tmr0 = 1'b1;
        end
        if (ioc_evt_i) begin
            next_st.flg_ioc = 1'b1;
        end

        // Sleep entry and wake on any enabled source
        if (sleep_i) begin
            next_st.sleeping = 1'b1;
        end
        if (st.sleeping && any_pend) begin
            next_st.sleeping  = 1'b0;
            next_st.post_wake = 1'b1;
        end
        if (st.post_wake && instr_done_i) begin
            next_st.post_wake = 1'b0;
        end

        // Interrupt entry sequence
        if (entry) begin
            next_st.global_irq_enable     = 1'b0;
            next_st.flush   = 1'b1;
            next_st.push    = 1'b1;
            next_st.push_pc = pc_i;
        end
        if (st.flush) begin
            next_st.vector = 1'b1;
        end

        // Return from handler
        if (return_from_irq_i) begin
            next_st.global_irq_enable     = 1'b1;
            next_st.pop     = 1'b1;
            next_st.restore = 1'b1;
        end

        // Register writes
        next_st.rd_shadow = bus_i.rd & is_shadow;
        if (bus_i.wr && !is_shadow) begin
            case (bus_i.addr)
                iwc_pkg::ADDR_CTRL: begin
                    if (!entry) begin
                        next_st.global_irq_enable = bus_i.wdata[iwc_pkg::CTRL_GIE_BIT];
                    end
                    next_st.peripheral_irq_enable =
                        bus_i.wdata[iwc_pkg::CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
                end
                iwc_pkg::ADDR_ENABLE0: begin
                    next_st.en_tmr0 = bus_i.wdata[iwc_pkg::EN_TMR0_BIT];
                    next_st.en_ioc  = bus_i.wdata[iwc_pkg::EN_IOC_BIT];
                    next_st.en_ext  = bus_i.wdata[iwc_pkg::EN_EXT_BIT];
                end
                iwc_pkg::ADDR_FLAG0: begin
                    // Software write, but a new event still wins
                    next_st.flg_tmr0 = tmr0_evt_i |
                        bus_i.wdata[iwc_pkg::EN_TMR0_BIT];
                    next_st.flg_ioc = ioc_evt_i |
                        bus_i.wdata[iwc_pkg::EN_IOC_BIT];
                    next_st.flg_ext = next_st.flg_ext &
                        (bus_i.wdata[iwc_pkg::EN_EXT_BIT] |
                         (ext_edge && st.q inside {iwc_pkg::IWC_Q4,
                                                   iwc_pkg::IWC_Q1}));
                end
                iwc_pkg::ADDR_IRQ_MASK: begin
                    next_st.ev_mask = bus_i.wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // Sticky event status, write one to clear, set wins
        ev_set[iwc_pkg::EV_EXT]   = next_st.flg_ext & ~st.flg_ext;
        ev_set[iwc_pkg::EV_WAKE]  = st.sleeping & any_pend;
        ev_set[iwc_pkg::EV_ENTRY] = entry;
        ev_set[iwc_pkg::EV_RET]   = return_from_irq_i;
        ev_clr = 4'h0;
        if (bus_i.wr && !is_shadow &&
            bus_i.addr == iwc_pkg::ADDR_IRQ_STAT) begin
            ev_clr = bus_i.wdata[3:0];
        end
        // Same-cycle event keeps its bit even when software clears it
        for (int i = 0; i < 4; i++) begin
            next_st.ev_stat[i] = w1c(st.ev_stat[i], ev_set[i], ev_clr[i]);
        end

        // Register reads, data one cycle later
        next_st.rdata = 8'h00;
        if (bus_i.rd && !is_shadow) begin
            case (bus_i.addr)
                iwc_pkg::ADDR_CTRL: begin
                    next_st.rdata[iwc_pkg::CTRL_GIE_BIT]  = st.global_irq_enable;
                    next_st.rdata[iwc_pkg::CTRL_PERIPHERAL_IRQ_ENABLE_BIT] = st.peripheral_irq_enable;
                    next_st.rdata[iwc_pkg::CTRL_EDGE_BIT] = st.edge_rise;
                end
                iwc_pkg::ADDR_ENABLE0: begin
                    next_st.rdata[iwc_pkg::EN_TMR0_BIT] = st.en_tmr0;
                    next_st.rdata[iwc_pkg::EN_IOC_BIT]  = st.en_ioc;
                    next_st.rdata[iwc_pkg::EN_EXT_BIT]  = st.en_ext;
                end
                iwc_pkg::ADDR_FLAG0: begin
                    next_st.rdata[iwc_pkg::EN_TMR0_BIT] = st.flg_tmr0;
                    next_st.rdata[iwc_pkg::EN_IOC_BIT]  = st.flg_ioc;
                    next_st.rdata[iwc_pkg::EN_EXT_BIT]  = st.flg_ext;
                end
                iwc_pkg::ADDR_IRQ_STAT: begin
                    next_st.rdata[3:0] = st.ev_stat;
                end
                iwc_pkg::ADDR_IRQ_MASK: begin
                    next_st.rdata[3:0] = st.ev_mask;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st           <= '0;
            st.edge_rise <= iwc_pkg::CTRL_RESET[iwc_pkg::CTRL_EDGE_BIT];
            st.q         <= iwc_pkg::IWC_Q1;
        end else begin
            st <= next_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata_o     = st.rd_shadow ? shadow_rdata : st.rdata;
    assign wake_o      = st.sleeping & any_pend;
    assign flush_o     = st.flush;
    assign push_o      = st.push;
    assign push_pc_o   = st.push_pc;
    assign vector_o    = st.vector;
    assign vector_pc_o = iwc_pkg::IRQ_VECTOR;
    assign pop_o       = st.pop;
    assign restore_o   = st.restore;
    assign qphase_o    = st.q;
    assign irq_o       = |(st.ev_stat & st.ev_mask);
endmodule : iwc_ctrl

// File: verif/iwc_checker.sv
// Port checker for the interrupt, wake and context unit.
// Assumes it is bound onto iwc_ctrl and sees only its ports.
`timescale 1ns/10ps
module iwc_checker (
    input wire logic              mclk_i,
    input wire logic              rst_b_i,
    input wire iwc_pkg::iwc_bus_t bus_i,
    input wire logic              instr_done_i,
    input wire logic              return_from_irq_i,
    input wire logic [14:0]       pc_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              wake_o,
    input wire logic              flush_o,
    input wire logic              push_o,
    input wire logic [14:0]       push_pc_o,
    input wire logic              vector_o,
    input wire logic [14:0]       vector_pc_o,
    input wire logic              pop_o,
    input wire logic              restore_o,
    input wire logic [1:0]        qphase_o
);
    default clocking dcb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    // Woken and the next instruction not yet retired
    logic woke;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            woke <= 1'b0;
        else if (wake_o)
            woke <= 1'b1;
        else if (instr_done_i)
            woke <= 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // Entry and return steps
    sequence s_entry;
        flush_o && push_o ##1 vector_o ##1 !vector_o;
    endsequence
    sequence s_return;
        pop_o && restore_o ##1 !pop_o;
    endsequence

    //////////////////////////////////////////////////////////////////////
    a_entry_order: assert property ($rose(push_o) |-> s_entry)
        else $error("entry pulses out of order");
    a_vector_addr: assert property (vector_o |-> vector_pc_o == 15'h0004)
        else $error("vector address wrong");
    a_vec_after_push: assert property (vector_o |-> $past(push_o))
        else $error("vector without push");
    a_push_pc: assert property (push_o |-> push_pc_o == $past(pc_i))
        else $error("pushed address differs from core address");
    a_ret_restore: assert property (return_from_irq_i |=> s_return)
        else $error("return did not pop and restore");
    a_read_idle: assert property (!bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data outside read answer");
    a_qphase_step: assert property ($past(rst_b_i) |->
        qphase_o == $past(qphase_o) + 2'd1)
        else $error("phase counter skipped");
    a_wake_first: assert property (woke |-> !push_o)
        else $error("entry before post-wake instruction");
    c_entry: cover property (push_o && flush_o);
endmodule : iwc_checker

bind iwc_ctrl iwc_checker u_chk (.mclk_i, .rst_b_i, .bus_i, .instr_done_i,
    .return_from_irq_i, .pc_i, .rdata_o, .wake_o, .flush_o, .push_o, .push_pc_o,
    .vector_o, .vector_pc_o, .pop_o, .restore_o, .qphase_o);

// File: verif/iwc_core_model.sv
// Core sequencer model facing the interrupt unit.
// Assumes one clock; one instruction retires every four cycles while awake.
`timescale 1ns/10ps
module iwc_core_model (
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire logic              go_sleep_i,
    input  wire logic              go_ret_i,
    input  wire logic              wake_i,
    input  wire logic              push_i,
    input  wire logic [14:0]       push_pc_i,
    input  wire logic              vector_i,
    input  wire logic [14:0]       vector_pc_i,
    input  wire logic              pop_i,
    input  wire logic              restore_i,
    input  wire iwc_pkg::iwc_ctx_t restore_ctx_i,
    output logic                   sleep_o,
    output logic                   return_from_irq_o,
    output logic                   instr_done_o,
    output logic [14:0]            pc_o,
    output iwc_pkg::iwc_ctx_t      ctx_o
);
    logic [1:0]  cnt;
    logic        asleep;
    logic [14:0] stack;

    // Retire, sleep, stack and context handling
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 2'h0;
            asleep <= 1'b0;
            stack <= 15'h0000;
            sleep_o <= 1'b0;
            return_from_irq_o <= 1'b0;
            instr_done_o <= 1'b0;
            pc_o <= 15'h0123;
            ctx_o <= {8'hA5, 8'hFF, 8'h3C, 8'h01, 8'h02, 8'h03, 8'h04, 8'h12};
        end else begin
            cnt <= cnt + 2'h1;
            sleep_o <= go_sleep_i;
            return_from_irq_o <= go_ret_i;
            instr_done_o <= (cnt == 2'h3) && !asleep && !go_sleep_i;
            if (go_sleep_i)
                asleep <= 1'b1;
            else if (wake_i)
                asleep <= 1'b0;
            if (push_i)
                stack <= push_pc_i;
            if (vector_i) begin
                pc_o <= vector_pc_i;
                ctx_o.w <= 8'h77; // Handler scribbles on W
            end
            if (pop_i)
                pc_o <= stack;
            if (restore_i)
                ctx_o <= restore_ctx_i;
        end
    end
endmodule : iwc_core_model

// File: verif/irq_wake_context_unit_bench.sv
// Self-checking bench for the interrupt, wake and context unit.
// Assumes the core model and the bound port checker.
`timescale 1ns/10ps
module irq_wake_context_unit_bench;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    iwc_pkg::iwc_bus_t bus = '0;
    logic [7:0] bank = 8'h00;
    logic [7:0] sel = 8'h00;
    logic [7:0] rdata;
    logic [3:0] pflag = 4'h0, pen = 4'h0;
    logic ext_pin = 1'b0, tmr0_evt = 1'b0, ioc_evt = 1'b0;
    logic go_sleep = 1'b0, go_ret = 1'b0;
    logic sleep, done, ret, wake, flush, push, vec, pop, rest, irq;
    logic [14:0] pc, push_pc, vec_pc;
    logic [1:0] q;
    iwc_pkg::iwc_ctx_t ctx, rctx;
    int errors = 0, tests_run = 0, pw, ww;

    always #20 mclk_i = ~mclk_i;

    //////////////////////////////////////////////////////////////////////
    // Unit and core model
    iwc_ctrl u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus),
        .bank_i(bank), .rdata_o(rdata), .ext_pin_i(ext_pin),
        .tmr0_evt_i(tmr0_evt), .ioc_evt_i(ioc_evt), .periph_flag_i(pflag),
        .periph_en_i(pen), .sleep_i(sleep), .instr_done_i(done),
        .return_from_irq_i(ret), .pc_i(pc), .ctx_i(ctx), .wake_o(wake),
        .flush_o(flush), .push_o(push), .push_pc_o(push_pc),
        .vector_o(vec), .vector_pc_o(vec_pc), .pop_o(pop),
        .restore_o(rest), .restore_ctx_o(rctx), .qphase_o(q), .irq_o(irq));
    iwc_core_model u_core (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .go_sleep_i(go_sleep), .go_ret_i(go_ret), .wake_i(wake),
        .push_i(push), .push_pc_i(push_pc), .vector_i(vec),
        .vector_pc_i(vec_pc), .pop_i(pop), .restore_i(rest),
        .restore_ctx_i(rctx), .sleep_o(sleep), .return_from_irq_o(ret),
        .instr_done_o(done), .pc_o(pc), .ctx_o(ctx));

    //////////////////////////////////////////////////////////////////////
    // Register port and compare tasks
    task automatic chk(input string n, input logic [14:0] e,
                       input logic [14:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        bank <= sel;
        @(posedge mclk_i);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        bank <= sel;
        @(posedge mclk_i);
        bus.rd <= 1'b0;
        #1 chk("read data", {7'h00, e}, {7'h00, rdata});
    endtask : chk_rd
    // Low, then rise on the clock edge that starts Q4
    task automatic pin_edge;
        @(posedge mclk_i);
        ext_pin <= 1'b0;
        repeat (4) @(posedge mclk_i);
        #1 while (q !== 2'd2) begin
            @(posedge mclk_i);
            #1;
        end
        @(posedge mclk_i);
        ext_pin <= 1'b1;
    endtask : pin_edge
    // Watch for wake and entry over a window
    task automatic watch;
        pw = 0;
        ww = 0;
        repeat (40) begin
            @(posedge mclk_i);
            #1 if (push === 1'b1) pw = 1;
            if (wake === 1'b1) ww = 1;
        end
    endtask : watch
    task automatic ret_pulse;
        @(posedge mclk_i);
        go_ret <= 1'b1;
        @(posedge mclk_i);
        go_ret <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask : ret_pulse
    task automatic stop_test;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    //////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        chk_rd(iwc_pkg::ADDR_CTRL, 8'h01);
        chk_rd(iwc_pkg::ADDR_ENABLE0, 8'h00);
        chk_rd(8'h30, 8'h00);
        wr(iwc_pkg::ADDR_CTRL, 8'h40);
        chk_rd(iwc_pkg::ADDR_CTRL, 8'h41);
        @(posedge mclk_i);
        tmr0_evt <= 1'b1;
        ioc_evt <= 1'b1;
        @(posedge mclk_i);
        tmr0_evt <= 1'b0;
        ioc_evt <= 1'b0;
        chk_rd(iwc_pkg::ADDR_FLAG0, 8'h30);
        wr(iwc_pkg::ADDR_FLAG0, 8'h00);
        wr(iwc_pkg::ADDR_ENABLE0, 8'h01);
        wr(iwc_pkg::ADDR_IRQ_MASK, 8'h01);
        pin_edge;
        repeat (6) @(posedge mclk_i);
        chk_rd(iwc_pkg::ADDR_FLAG0, 8'h01);
        chk("irq", 15'h1, {14'h0, irq});
        wr(iwc_pkg::ADDR_IRQ_STAT, 8'h0F);
        @(posedge mclk_i);
        #1 chk("irq", 15'h0, {14'h0, irq});
        // Enabling global interrupts serves the held flag
        wr(iwc_pkg::ADDR_CTRL, 8'hC0);
        watch;
        chk("entry", 15'h1, 15'(pw));
        chk("irq", 15'h0, {14'h0, irq});
        chk_rd(iwc_pkg::ADDR_CTRL, 8'h41);
        wr(iwc_pkg::ADDR_FLAG0, 8'h00);
        sel = iwc_pkg::SHADOW_BANK;
        chk_rd(iwc_pkg::ADDR_SHADOW_HI, 8'hA5);
        chk_rd(8'h16, 8'hE7);
        chk_rd(iwc_pkg::ADDR_SHADOW_LO, 8'h12);
        wr(iwc_pkg::ADDR_SHADOW_HI, 8'h5A);
        chk_rd(iwc_pkg::ADDR_SHADOW_HI, 8'h5A);
        sel = 8'h00;
        ret_pulse;
        #1 chk("live w", 15'h5A, {7'h0, ctx.w});
        chk("pc", 15'h0123, pc);
        chk_rd(iwc_pkg::ADDR_CTRL, 8'hC1);
        // Sleep with global enable clear, then set
        for (int g = 0; g < 2; g++) begin
            wr(iwc_pkg::ADDR_CTRL, g ? 8'h80 : 8'h00);
            @(posedge mclk_i);
            go_sleep <= 1'b1;
            @(posedge mclk_i);
            go_sleep <= 1'b0;
            pin_edge;
            watch;
            chk("wake", 15'h1, 15'(ww));
            chk("vector", 15'(g), 15'(pw));
            wr(iwc_pkg::ADDR_FLAG0, 8'h00);
            if (g == 1)
                ret_pulse;
        end
        // Peripheral source waits for the peripheral enable
        @(posedge mclk_i);
        pflag <= 4'h1;
        pen <= 4'h1;
        watch;
        chk("periph blocked", 15'h0, 15'(pw));
        wr(iwc_pkg::ADDR_CTRL, 8'hC0);
        watch;
        chk("periph entry", 15'h1, 15'(pw));
        pflag <= 4'h0;
        stop_test();
    end

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        errors++;
        stop_test();
    end
endmodule : irq_wake_context_unit_bench
